// *** rtl/pvc_priority_vector_controller.v ***
// Priority vector controller: sorts peripheral requests into three classes.
// What this block does
// - Fast requests take precedence over all vectored and plain requests.
// - All fast-class requests merge into one fast interrupt output.
// - A status word shows requesting fast sources, one bit each.
// - Sixteen vectored slots; any channel may be assigned to any slot.
// - Slot 0 wins over all slots, slot 15 loses, fixed order.
// - Vectored rank below fast; plain requests rank below vectored.
// - Normal interrupt output is high while any vectored or plain request.
// - Vector address gives handler of the best requesting vectored slot.
// - With no vectored request, vector address gives the default handler.
// - A status word shows active normal-interrupt requests.
// - Class and slot settings are programmable at run time.
// - Channel 0 is watchdog; channel 1 is software only.
// - Channels 2,3 debug comms; channels 4,5 timer 0 and 1 events.
// - Channels 6,7 carry the serial ports' four request kinds.
// - Channel 7 also carries the second port's modem status change.
// - Channel 12 synthesizer lock, channel 13 clock count and alarm.
// - Channels 14 to 16 carry external requests zero to two.
`timescale 1ns/1ps
`default_nettype none
`include "pvc_regs.vh"
module pvc_priority_vector_controller #(
  parameter CHANNELS = `PVC_CHANNELS,
  parameter SLOTS = `PVC_SLOTS,
  parameter CH_W = `PVC_CH_BITS,
  parameter ADDR_W = `PVC_ADDR_W
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_watchdog_timeout_flag,
  input wire i_soft_request,
  input wire i_debug_comms_receive,
  input wire i_debug_comms_transmit,
  input wire [`PVC_TIMER_EVENTS-1:0] i_timer0_flags,
  input wire [`PVC_TIMER_EVENTS-1:0] i_timer1_flags,
  input wire i_serial0_receive_line_status,
  input wire i_serial0_transmit_holding_empty,
  input wire i_serial0_receive_data_available,
  input wire i_serial0_character_timeout,
  input wire i_serial1_receive_line_status,
  input wire i_serial1_transmit_holding_empty,
  input wire i_serial1_receive_data_available,
  input wire i_serial1_character_timeout,
  input wire i_serial1_modem_status_change,
  input wire [`PVC_PWM_MATCHES-1:0] i_pwm_match_flags,
  input wire i_i2c_state_change,
  input wire i_spi_transfer_done,
  input wire i_spi_mode_fault,
  input wire i_synth_lock_flag,
  input wire i_clock_counter_increment,
  input wire i_clock_alarm_flag,
  input wire i_external_request_zero,
  input wire i_external_request_one,
  input wire i_external_request_two,
  input wire [CHANNELS-1:0] i_enable_mask,
  input wire [CHANNELS-1:0] i_fast_select,
  input wire i_slot_wr,
  input wire [3:0] i_slot_index,
  input wire [CH_W-1:0] i_slot_channel,
  input wire i_slot_enable,
  input wire [ADDR_W-1:0] i_slot_addr,
  input wire i_default_wr,
  input wire [ADDR_W-1:0] i_default_addr,
  output reg o_fast_interrupt_request,
  output reg o_normal_interrupt_request,
  output reg [CHANNELS-1:0] o_fast_status,
  output reg [CHANNELS-1:0] o_normal_status,
  output reg [CHANNELS-1:0] o_raw_status,
  output reg [ADDR_W-1:0] o_vector_addr,
  output reg o_vector_hit,
  output reg [3:0] o_vector_slot
);
  // ****************************************
  // Request gathering
  // ****************************************
  // Peripheral flags are merged here so that one line per channel enters
  // the sorting logic, whatever each peripheral holds inside.
  wire [CHANNELS-1:0] raw;
  assign raw[`PVC_CH_WATCHDOG] = i_watchdog_timeout_flag;
  assign raw[`PVC_CH_SOFT] = i_soft_request;
  assign raw[`PVC_CH_DBG_RX] = i_debug_comms_receive;
  assign raw[`PVC_CH_DBG_TX] = i_debug_comms_transmit;
  assign raw[`PVC_CH_TIMER0] = |i_timer0_flags;
  assign raw[`PVC_CH_TIMER1] = |i_timer1_flags;
  assign raw[`PVC_CH_SERIAL0] = i_serial0_receive_line_status |
    i_serial0_transmit_holding_empty | i_serial0_receive_data_available |
    i_serial0_character_timeout;
  assign raw[`PVC_CH_SERIAL1] = i_serial1_receive_line_status |
    i_serial1_transmit_holding_empty | i_serial1_receive_data_available |
    i_serial1_character_timeout | i_serial1_modem_status_change;
  assign raw[`PVC_CH_PWM] = |i_pwm_match_flags;
  assign raw[`PVC_CH_I2C] = i_i2c_state_change;
  assign raw[`PVC_CH_SPI] = i_spi_transfer_done | i_spi_mode_fault;
  assign raw[`PVC_CH_UNUSED] = 1'b0;
  assign raw[`PVC_CH_SYNTH] = i_synth_lock_flag;
  assign raw[`PVC_CH_RTC] = i_clock_counter_increment |
    i_clock_alarm_flag;
  assign raw[`PVC_CH_EXT0] = i_external_request_zero;
  assign raw[`PVC_CH_EXT1] = i_external_request_one;
  assign raw[`PVC_CH_EXT2] = i_external_request_two;

  // ****************************************
  // Class settings
  // ****************************************
  reg [CHANNELS-1:0] enables;
  reg [CHANNELS-1:0] fast_sel;
  reg [ADDR_W-1:0] default_addr;
  // Enables and fast selects are sampled every cycle so software may retune at run time; default_addr only on i_default_wr.
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      enables <= {CHANNELS{1'b0}};
      fast_sel <= {CHANNELS{1'b0}};
      default_addr <= `PVC_RST_DEFAULT_ADDR;
    end else begin
      enables <= i_enable_mask;
      fast_sel <= i_fast_select;
      if (i_default_wr) begin
        default_addr <= i_default_addr;
      end
    end
  end

  wire [SLOTS*CH_W-1:0] slot_channels;
  wire [SLOTS-1:0] slot_enables;
  wire [SLOTS*ADDR_W-1:0] slot_addrs;
  pvc_slot_table #(
    .SLOTS(SLOTS),
    .CH_W(CH_W),
    .ADDR_W(ADDR_W)
  ) u_slots (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_wr(i_slot_wr),
    .i_slot(i_slot_index),
    .i_channel(i_slot_channel),
    .i_enable(i_slot_enable),
    .i_addr(i_slot_addr),
    .o_channels(slot_channels),
    .o_enables(slot_enables),
    .o_addrs(slot_addrs)
  );

  // ****************************************
  // Classification
  // ****************************************
  wire [CHANNELS-1:0] active = raw & enables;
  wire [CHANNELS-1:0] fast_req = active & fast_sel;
  wire [CHANNELS-1:0] norm_req = active & ~fast_sel;
  wire [SLOTS-1:0] slot_req;
  wire [SLOTS*CHANNELS-1:0] slot_claims;
  genvar s;
  generate
    for (s = 0; s < SLOTS; s = s + 1) begin : claim
      wire [CH_W-1:0] ch = slot_channels[s*CH_W +: CH_W];
      wire valid = slot_enables[s] && (ch < CHANNELS);
      // A fast channel never counts as vectored, which keeps fast first.
      assign slot_req[s] = valid && norm_req[ch];
      assign slot_claims[s*CHANNELS +: CHANNELS] =
        valid ? ({{(CHANNELS-1){1'b0}}, 1'b1} << ch) : {CHANNELS{1'b0}};
    end
  endgenerate

  reg [CHANNELS-1:0] vectored_ch;
  integer k;
  always @* begin
    vectored_ch = {CHANNELS{1'b0}};
    for (k = 0; k < SLOTS; k = k + 1) begin
      vectored_ch = vectored_ch | slot_claims[k*CHANNELS +: CHANNELS];
    end
  end
  // Unassigned enabled channels not selected as fast fall through to the plain class.
  wire [CHANNELS-1:0] plain_req = norm_req & ~vectored_ch;

  // ****************************************
  // Slot arbitration
  // ****************************************
  reg next_hit;
  reg [3:0] next_slot;
  reg [ADDR_W-1:0] next_addr;
  integer j;
  always @* begin
    next_hit = 1'b0;
    next_slot = 4'h0;
    next_addr = default_addr;
    // Walk downward so that the lowest numbered slot is assigned last.
    for (j = SLOTS - 1; j >= 0; j = j - 1) begin
      if (slot_req[j]) begin
        next_hit = 1'b1;
        next_slot = j[3:0];
        next_addr = slot_addrs[j*ADDR_W +: ADDR_W];
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Registering costs one cycle of latency but gives glitch-free lines.
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_fast_interrupt_request <= 1'b0;
      o_normal_interrupt_request <= 1'b0;
      o_fast_status <= {CHANNELS{1'b0}};
      o_normal_status <= {CHANNELS{1'b0}};
      o_raw_status <= {CHANNELS{1'b0}};
      o_vector_addr <= `PVC_RST_DEFAULT_ADDR;
      o_vector_hit <= 1'b0;
      o_vector_slot <= 4'h0;
    end else begin
      o_fast_interrupt_request <= |fast_req;
      o_normal_interrupt_request <= (|slot_req) | (|plain_req);
      o_fast_status <= fast_req;
      o_normal_status <= norm_req;
      o_raw_status <= raw;
      o_vector_addr <= next_addr;
      o_vector_hit <= next_hit;
      o_vector_slot <= next_slot;
    end
  end
endmodule
`default_nettype wire

// *** rtl/pvc_regs.vh ***
// Constants of the priority vector controller.
`ifndef PVC_REGS_VH
`define PVC_REGS_VH
`define PVC_CHANNELS 17
`define PVC_SLOTS 16
`define PVC_SLOT_BITS 4
`define PVC_CH_BITS 5
`define PVC_ADDR_W 32
`define PVC_CH_WATCHDOG 0
`define PVC_CH_SOFT 1
`define PVC_CH_DBG_RX 2
`define PVC_CH_DBG_TX 3
`define PVC_CH_TIMER0 4
`define PVC_CH_TIMER1 5
`define PVC_CH_SERIAL0 6
`define PVC_CH_SERIAL1 7
`define PVC_CH_PWM 8
`define PVC_CH_I2C 9
`define PVC_CH_SPI 10
`define PVC_CH_UNUSED 11
`define PVC_CH_SYNTH 12
`define PVC_CH_RTC 13
`define PVC_CH_EXT0 14
`define PVC_CH_EXT1 15
`define PVC_CH_EXT2 16
`define PVC_PWM_MATCHES 7
`define PVC_TIMER_EVENTS 8
`define PVC_RST_DEFAULT_ADDR 32'h00000000
`endif

// *** rtl/pvc_slot_table.v ***
// Per-slot storage of vectored slot settings: channel, enable, address.
`timescale 1ns/1ps
`default_nettype none
module pvc_slot_table #(
  parameter SLOTS = 16,
  parameter CH_W = 5,
  parameter ADDR_W = 32
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_wr,
  input wire [3:0] i_slot,
  input wire [CH_W-1:0] i_channel,
  input wire i_enable,
  input wire [ADDR_W-1:0] i_addr,
  output reg [SLOTS*CH_W-1:0] o_channels,
  output reg [SLOTS-1:0] o_enables,
  output reg [SLOTS*ADDR_W-1:0] o_addrs
);
  // ****************************************
  // Slot registers
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < SLOTS; g = g + 1) begin : slot
      always @(posedge i_core_clk) begin
        if (i_rst) begin
          o_channels[g*CH_W +: CH_W] <= {CH_W{1'b0}};
          o_enables[g] <= 1'b0;
          o_addrs[g*ADDR_W +: ADDR_W] <= {ADDR_W{1'b0}};
        end else if (i_wr && (i_slot == g)) begin
          o_channels[g*CH_W +: CH_W] <= i_channel;
          o_enables[g] <= i_enable;
          o_addrs[g*ADDR_W +: ADDR_W] <= i_addr;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// *** dv/pvc_periph_model.sv ***
// Peripheral side model: one request per channel raises one of that peripheral's flags, chosen by i_pick.
`timescale 1ns/1ps
`default_nettype none
module pvc_periph_model (
  input wire logic [16:0] i_req,
  input wire logic [3:0] i_pick,
  output logic [44:0] o_flags
);
  // Flag count per channel; channel 11 has no source at all.
  localparam int W [17] = '{1, 1, 1, 1, 8, 8, 4, 5, 7, 1, 2, 0, 1, 2, 1, 1, 1};
  always_comb begin
    int b;
    b = 0;
    o_flags = '0;
    for (int c = 0; c < 17; c++) begin
      if (W[c] > 0) begin
        if (i_req[c]) o_flags[b + i_pick % W[c]] = 1'b1;
        b += W[c];
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/pvc_checker.sv ***
// Concurrent checks on the controller's ports.
`timescale 1ns/1ps
`default_nettype none
module pvc_checker (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_external_request_zero,
  input wire [16:0] i_enable_mask,
  input wire o_fast_interrupt_request,
  input wire o_normal_interrupt_request,
  input wire [16:0] o_fast_status,
  input wire [16:0] o_normal_status,
  input wire [16:0] o_raw_status,
  input wire o_vector_hit,
  input wire [3:0] o_vector_slot
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  property p_fm; o_fast_interrupt_request == |o_fast_status; endproperty
  a_fm: assert property (p_fm) else $error("fast merge");
  property p_nm; o_normal_interrupt_request == |o_normal_status; endproperty
  a_nm: assert property (p_nm) else $error("normal merge");
  property p_dj; (o_fast_status & o_normal_status) == 17'h0; endproperty
  a_dj: assert property (p_dj) else $error("fast also normal");
  property p_ns; (o_normal_status & ~o_raw_status) == 17'h0; endproperty
  a_ns: assert property (p_ns) else $error("normal not raw");
  property p_hn; o_vector_hit |-> o_normal_interrupt_request; endproperty
  a_hn: assert property (p_hn) else $error("hit no normal");
  property p_sl; !o_vector_hit |-> o_vector_slot == 4'h0; endproperty
  a_sl: assert property (p_sl) else $error("slot no hit");
  property p_c11; o_raw_status[11] == 1'b0; endproperty
  a_c11: assert property (p_c11) else $error("channel 11");
  property p_mz;
    (i_enable_mask == 17'h0) [*3] |=> (o_normal_status == 17'h0);
  endproperty
  a_mz: assert property (p_mz) else $error("mask ignored");
  property p_ex; i_external_request_zero |=> o_raw_status[14]; endproperty
  a_ex: assert property (p_ex) else $error("external zero");
  c_fast: cover property (o_fast_interrupt_request);
  c_low: cover property (o_vector_hit && o_vector_slot == 4'hf);
  c_def: cover property (o_normal_interrupt_request && !o_vector_hit);
endmodule
`default_nettype wire

// *** dv/test_vectored_interrupt_controller.sv ***
// Self-checking bench of the priority vector controller.
`timescale 1ns/1ps
`default_nettype none
module test_vectored_interrupt_controller;
  logic clk = 0, rst = 1, swr = 0, sen = 0, dwr = 0;
  logic [16:0] req = 0, mask = 0, fsel = 0;
  logic [3:0] pick = 0, sidx = 0;
  logic [4:0] sch = 0;
  logic [31:0] sa = 0, da = 0;
  logic [44:0] f;
  wire fo, no, hit;
  wire [16:0] fs, ns, rs;
  wire [31:0] va;
  wire [3:0] vs;
  int miscompares = 0, n_compared = 0;
  initial forever #12.5 clk = ~clk;
  pvc_periph_model pvc_periph_model_i (.i_req(req), .i_pick(pick), .o_flags(f));
  pvc_priority_vector_controller pvc_priority_vector_controller_i (
    .i_core_clk(clk), .i_rst(rst), .i_watchdog_timeout_flag(f[0]),
    .i_soft_request(f[1]), .i_debug_comms_receive(f[2]),
    .i_debug_comms_transmit(f[3]), .i_timer0_flags(f[11:4]),
    .i_timer1_flags(f[19:12]), .i_serial0_receive_line_status(f[20]),
    .i_serial0_transmit_holding_empty(f[21]),
    .i_serial0_receive_data_available(f[22]),
    .i_serial0_character_timeout(f[23]),
    .i_serial1_receive_line_status(f[24]),
    .i_serial1_transmit_holding_empty(f[25]),
    .i_serial1_receive_data_available(f[26]),
    .i_serial1_character_timeout(f[27]),
    .i_serial1_modem_status_change(f[28]), .i_pwm_match_flags(f[35:29]),
    .i_i2c_state_change(f[36]), .i_spi_transfer_done(f[37]),
    .i_spi_mode_fault(f[38]), .i_synth_lock_flag(f[39]),
    .i_clock_counter_increment(f[40]), .i_clock_alarm_flag(f[41]),
    .i_external_request_zero(f[42]), .i_external_request_one(f[43]),
    .i_external_request_two(f[44]), .i_enable_mask(mask),
    .i_fast_select(fsel), .i_slot_wr(swr), .i_slot_index(sidx),
    .i_slot_channel(sch), .i_slot_enable(sen), .i_slot_addr(sa),
    .i_default_wr(dwr), .i_default_addr(da),
    .o_fast_interrupt_request(fo), .o_normal_interrupt_request(no),
    .o_fast_status(fs), .o_normal_status(ns), .o_raw_status(rs),
    .o_vector_addr(va), .o_vector_hit(hit), .o_vector_slot(vs));
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Four edges cover the two-edge settings latency with two to spare.
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic slot(logic [3:0] i, logic [4:0] c, logic [31:0] a);
    @(posedge clk);
    {swr, sen, sidx, sch, sa} <= {2'b11, i, c, a};
    @(posedge clk);
    swr <= 1'b0;
  endtask
  task automatic t_map;
    mask <= '1;
    for (int c = 0; c < 17; c++)
      for (int p = 0; p < 8; p++) begin
        @(posedge clk);
        req <= 17'h1 << c;
        pick <= p[3:0];
        settle();
        chk("raw", rs, c == 11 ? 0 : 32'h1 << c);
        chk("plain", {ns, no}, c == 11 ? 0 : {17'h1 << c, 1'b1});
        chk("default", {fo, hit, va[29:0]}, 0);
      end
  endtask
  task automatic t_fast;
    slot(0, 14, 32'h100);
    @(posedge clk);
    fsel <= 17'h04001;
    req <= 17'h04005;
    settle();
    chk("fast", {fo, fs}, {1'b1, 17'h04001});
    chk("normal", {no, ns, hit}, {1'b1, 17'h4, 1'b0});
    @(posedge clk);
    fsel <= '0;
    settle();
    chk("vector", {hit, vs, va[15:0]}, 21'h100100);
  endtask
  task automatic t_vec;
    logic [16:0] rq [6] = '{17'h20, 17'h220, 17'h4220, 17'h4, 0, 17'h220};
    logic [20:0] ex [6] = '{21'h1f0f00, 21'h130300, 21'h100100, 21'h000d00,
                           21'h000d00, 21'h100500};
    slot(15, 5, 32'hf00);
    slot(3, 9, 32'h300);
    slot(7, 20, 32'h700);
    @(posedge clk);
    {dwr, da} <= {1'b1, 32'hd00};
    @(posedge clk);
    dwr <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      if (k == 5) slot(0, 5, 32'h500);
      @(posedge clk);
      req <= rq[k];
      settle();
      chk("winner", {hit, vs, va[15:0]}, ex[k]);
    end
  endtask
  task automatic t_reset;
    @(posedge clk);
    {rst, mask, req} <= {1'b1, 17'h0, 17'h20};
    settle();
    chk("reset", {no, hit, rs}, 0);
    @(posedge clk);
    rst <= 1'b0;
    settle();
    chk("masked", {no, ns}, 0);
    @(posedge clk);
    mask <= '1;
    settle();
    chk("cleared", {hit, va[13:0], ns}, 32'h20);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_map();
    t_fast();
    t_vec();
    t_reset();
    wrap_up();
  end
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
endmodule
bind pvc_priority_vector_controller pvc_checker pvc_checker_i (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_enable_mask(i_enable_mask),
  .i_external_request_zero(i_external_request_zero),
  .o_fast_interrupt_request(o_fast_interrupt_request),
  .o_normal_interrupt_request(o_normal_interrupt_request),
  .o_fast_status(o_fast_status), .o_normal_status(o_normal_status),
  .o_raw_status(o_raw_status), .o_vector_hit(o_vector_hit),
  .o_vector_slot(o_vector_slot));
`default_nettype wire
